// [hw/ppd_top.sv]
// module: parallel port direction, handshake delays and byte match interrupts
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ppd_top
	import ppd_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// host byte capture
	input  wire logic        rxValid,
	input  wire logic [7:0]  rxData,
	// handshake timing
	input  wire logic        hsStart,
	output logic             shortDone,
	output logic             longDone,
	output logic             hsBusy,
	// direction and interrupt
	output logic             transferDirection,
	output logic             byteMatchIrq
);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        setup;
	logic        doWrite;
	logic        doRead;
	logic [28:0] decAddr;
	logic        known;

	assign setup   = psel && !penable;
	assign doWrite = psel && penable && pwrite && pready;
	assign doRead  = psel && penable && !pwrite;
	assign decAddr = paddr[DEC_W-1:0];

	always_comb
	begin
		if (decAddr == OFS_MATCH_A)
			known = 1'b1;
		else if (decAddr == OFS_MATCH_B)
			known = 1'b1;
		else if (decAddr == OFS_MATCH_C)
			known = 1'b1;
		else if (decAddr == OFS_MIN_DELAY)
			known = 1'b1;
		else if (decAddr == OFS_PORT_MODE)
			known = 1'b1;
		else if (decAddr == OFS_IRQ_STATUS)
			known = 1'b1;
		else if (decAddr == OFS_IRQ_CLEAR)
			known = 1'b1;
		else if (decAddr == OFS_IRQ_ENABLE)
			known = 1'b1;
		else
			known = 1'b0;
	end

	// no wait state: pready rises in the first access cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pready <= 1'b0;
		else
			pready <= setup;
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [MATCH_W-1:0] matchValue [NUM_MATCH];
	logic [DLY_W-1:0]   shortDelay;
	logic [DLY_W-1:0]   longDelay;
	logic [NUM_MATCH-1:0] irqEnable;
	logic [NUM_MATCH-1:0] irqStatus;
	logic [NUM_MATCH-1:0] clearPulse;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			matchValue[0] <= RST_MATCH;
			matchValue[1] <= RST_MATCH;
			matchValue[2] <= RST_MATCH;
		end
		else if (doWrite)
		begin
			if (decAddr == OFS_MATCH_A)
				matchValue[0] <= pwdata[MATCH_W-1:0];
			else if (decAddr == OFS_MATCH_B)
				matchValue[1] <= pwdata[MATCH_W-1:0];
			else if (decAddr == OFS_MATCH_C)
				matchValue[2] <= pwdata[MATCH_W-1:0];
		end
	end

	// delays stored exactly as written, no clamping to the standard minimum
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			shortDelay <= RST_SHORT_DLY;
			longDelay  <= RST_LONG_DLY;
		end
		else if (doWrite && decAddr == OFS_MIN_DELAY)
		begin
			shortDelay <= pwdata[SHORT_LSB +: DLY_W];
			longDelay  <= pwdata[LONG_LSB +: DLY_W];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			transferDirection <= 1'b0;
		else if (doWrite && decAddr == OFS_PORT_MODE)
			transferDirection <= pwdata[DIR_BIT];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			irqEnable <= '0;
		else if (doWrite && decAddr == OFS_IRQ_ENABLE)
			irqEnable <= pwdata[IRQ_LSB +: NUM_MATCH];
	end

	assign clearPulse = (doWrite && decAddr == OFS_IRQ_CLEAR) ?
		pwdata[IRQ_LSB +: NUM_MATCH] : '0;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] next_prdata;

	always_comb
	begin
		next_prdata = '0;
		if (decAddr == OFS_MATCH_A)
			next_prdata[MATCH_W-1:0] = matchValue[0];
		else if (decAddr == OFS_MATCH_B)
			next_prdata[MATCH_W-1:0] = matchValue[1];
		else if (decAddr == OFS_MATCH_C)
			next_prdata[MATCH_W-1:0] = matchValue[2];
		else if (decAddr == OFS_MIN_DELAY)
		begin
			next_prdata[SHORT_LSB +: DLY_W] = shortDelay;
			next_prdata[LONG_LSB +: DLY_W]  = longDelay;
		end
		else if (decAddr == OFS_PORT_MODE)
			next_prdata[DIR_BIT] = transferDirection;
		else if (decAddr == OFS_IRQ_STATUS)
			next_prdata[IRQ_LSB +: NUM_MATCH] = irqStatus;
		else if (decAddr == OFS_IRQ_ENABLE)
			next_prdata[IRQ_LSB +: NUM_MATCH] = irqEnable;
	end

	// read data and error are registered with pready so they meet it exactly
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= !known;
		end
		else if (doRead || doWrite)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// byte matching
	// ----------------------------------------------------------------
	logic       checkByte;
	logic [7:0] heldByte;

	// forward bytes only; the capture is registered so each is seen once
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			checkByte <= 1'b0;
			heldByte  <= 8'h00;
		end
		else
		begin
			checkByte <= rxValid && !transferDirection;
			if (rxValid)
				heldByte <= rxData;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_MATCH; gi++)
		begin : gMatch
			ppd_byte_matcher #(
				.W (MATCH_W)
			) uMatch (
				.clk    (clk),
				.nrst   (nrst),
				.check  (checkByte),
				.rxByte (heldByte),
				.value  (matchValue[gi]),
				.clear  (clearPulse[gi]),
				.hit    (irqStatus[gi])
			);
		end
	endgenerate

	// recording continues regardless of the enable
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			byteMatchIrq <= 1'b0;
		else
			byteMatchIrq <= |(irqStatus & irqEnable);
	end

	// ----------------------------------------------------------------
	// handshake interval sequencer
	// ----------------------------------------------------------------
	ppd_hs_e    hsState;
	logic       shortStart;
	logic       longStart;
	logic       shortFin;
	logic       longFin;

	assign shortStart = hsStart && hsState == HS_IDLE;
	assign longStart  = shortFin && hsState == HS_SHORT;

	ppd_delay_timer #(
		.W (DLY_W)
	) uShort (
		.clk   (clk),
		.nrst  (nrst),
		.start (shortStart),
		.count (shortDelay),
		.done  (shortFin)
	);

	ppd_delay_timer #(
		.W (DLY_W)
	) uLong (
		.clk   (clk),
		.nrst  (nrst),
		.start (longStart),
		.count (longDelay),
		.done  (longFin)
	);

	// short interval first, then the long one; a start while busy is ignored
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			hsState <= HS_IDLE;
		else
		begin
			case (hsState)
				HS_IDLE:
					if (hsStart)
						hsState <= HS_SHORT;
				HS_SHORT:
					if (shortFin)
						hsState <= HS_LONG;
				HS_LONG:
					if (longFin)
						hsState <= HS_IDLE;
				default:
					hsState <= HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			shortDone <= 1'b0;
			longDone  <= 1'b0;
			hsBusy    <= 1'b0;
		end
		else
		begin
			shortDone <= shortFin && hsState == HS_SHORT;
			longDone  <= longFin && hsState == HS_LONG;
			hsBusy    <= (hsState != HS_IDLE) || hsStart;
		end
	end

endmodule
`default_nettype wire

// [hw/ppd_pkg.sv]
// package: register map, field layout and constants for the parallel port delay and match block
package ppd_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, bits 31..29 not decoded)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W            = 32;
	localparam int unsigned DEC_W             = 29;
	localparam logic [28:0] OFS_MATCH_A       = 29'h1d0000a4;
	localparam logic [28:0] OFS_MATCH_B       = 29'h1d0000a8;
	localparam logic [28:0] OFS_MATCH_C       = 29'h1d0000ac;
	localparam logic [28:0] OFS_MIN_DELAY     = 29'h1d000114;
	localparam logic [28:0] OFS_PORT_MODE     = 29'h1d000110;
	localparam logic [28:0] OFS_IRQ_STATUS    = 29'h1d000120;
	localparam logic [28:0] OFS_IRQ_CLEAR     = 29'h1d000124;
	localparam logic [28:0] OFS_IRQ_ENABLE    = 29'h1d000128;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int unsigned DIR_BIT           = 3;
	localparam int unsigned SHORT_LSB         = 0;
	localparam int unsigned LONG_LSB          = 7;
	localparam int unsigned DLY_W             = 7;
	localparam int unsigned MATCH_W           = 8;
	localparam int unsigned NUM_MATCH         = 3;
	localparam int unsigned IRQ_LSB           = 14;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [6:0]  RST_SHORT_DLY     = 7'h28;
	localparam logic [6:0]  RST_LONG_DLY      = 7'h08;
	localparam logic [7:0]  RST_MATCH         = 8'h00;

	// handshake interval sequencer
	typedef enum logic [1:0]
	{
		HS_IDLE  = 2'b00,
		HS_SHORT = 2'b01,
		HS_LONG  = 2'b10
	} ppd_hs_e;

endpackage

// [hw/ppd_delay_timer.sv]
// module: loadable down counter that times one minimum handshake interval
`timescale 1ns/100ps
`default_nettype none
module ppd_delay_timer
	import ppd_pkg::*;
#(
	parameter int unsigned W = 7
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// control
	input  wire logic         start,
	input  wire logic [W-1:0] count,
	// status
	output logic              done
);

	logic [W-1:0] remain;
	logic         running;

	// a count of zero finishes in one cycle, so short counts stay usable
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			remain  <= '0;
			running <= 1'b0;
			done    <= 1'b0;
		end
		else if (start)
		begin
			remain  <= count;
			running <= 1'b1;
			done    <= 1'b0;
		end
		else if (running)
		begin
			if (remain == '0)
			begin
				running <= 1'b0;
				done    <= 1'b1;
			end
			else
				remain <= remain - 1'b1;
		end
		else
			done <= 1'b0;
	end

endmodule
`default_nettype wire

// [hw/ppd_byte_matcher.sv]
// module: one byte comparator with its sticky match flag
`timescale 1ns/100ps
`default_nettype none
module ppd_byte_matcher
	import ppd_pkg::*;
#(
	parameter int unsigned W = 8
)
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// compare
	input  wire logic         check,
	input  wire logic [W-1:0] rxByte,
	input  wire logic [W-1:0] value,
	// flag
	input  wire logic         clear,
	output logic              hit
);

	// set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			hit <= 1'b0;
		else if (check && rxByte == value)
			hit <= 1'b1;
		else if (clear)
			hit <= 1'b0;
	end

endmodule
`default_nettype wire

// [bench/ppd_top_sva.sv]
// checker: port level properties of the delay and match block
`timescale 1ns/100ps
`default_nettype none
module ppd_top_sva
(
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// host, handshake, status
	input wire logic        rxValid,
	input wire logic [7:0]  rxData,
	input wire logic        hsStart,
	input wire logic        shortDone,
	input wire logic        longDone,
	input wire logic        hsBusy,
	input wire logic        transferDirection,
	input wire logic        byteMatchIrq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// a write commits at the edge that samples pready
	wire logic wrDone = psel && penable && pready && pwrite;
	ready_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("slverr without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	dir_write_a: assert property ($changed(transferDirection) |-> $past(wrDone))
		else $error("direction moved without write");
	// enable and clear writes reach the registered irq one edge after they commit
	irq_rise_a: assert property ($rose(byteMatchIrq) |-> $past(rxValid, 3) || $past(wrDone, 2))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(byteMatchIrq) |-> $past(wrDone, 2))
		else $error("irq fell without write");
	start_busy_a: assert property (hsStart && !hsBusy |=> hsBusy)
		else $error("start not taken");
	short_busy_a: assert property (shortDone |-> hsBusy && !longDone)
		else $error("short done outside run");
	long_busy_a: assert property (longDone |-> hsBusy)
		else $error("long done outside run");
	short_pulse_a: assert property (shortDone |=> !shortDone)
		else $error("short done too long");
	cover property ($rose(byteMatchIrq));
	cover property (longDone);
	cover property (pslverr);
endmodule
`default_nettype wire

// [bench/ppd_host_model.sv]
// model: host side of the port, one captured byte per call
`timescale 1ns/100ps
`default_nettype none
module ppd_host_model
(
	// clock
	input wire logic       clk,
	// captured byte
	output var logic       rxValid,
	output var logic [7:0] rxData
);
	initial
	begin
		rxValid = 1'b0;
		rxData = 8'hff;
	end
	// inverse after the byte so stale data can never pass for a match
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rxValid <= 1'b1;
		rxData <= b;
		@(posedge clk);
		rxValid <= 1'b0;
		rxData <= ~b;
	endtask
endmodule
`default_nettype wire

// [bench/parallel_port_delay_and_match_bench.sv]
// testbench: register, match interrupt and handshake timing scenarios
`timescale 1ns/100ps
`default_nettype none
module parallel_port_delay_and_match_bench
	import ppd_pkg::*;
;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        hsStart = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxValid;
	logic [7:0]  rxData;
	logic        shortDone;
	logic        longDone;
	logic        hsBusy;
	logic        transferDirection;
	logic        byteMatchIrq;
	logic [31:0] rdv;
	logic        erv;
	int          n_fail = 0;
	int          n_compared = 0;
	logic [28:0] mo [3] = '{OFS_MATCH_A, OFS_MATCH_B, OFS_MATCH_C};
	logic [7:0]  mv [3] = '{8'h5a, 8'ha5, 8'h3c};

	always #2 clk = ~clk;

	ppd_top u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxValid(rxValid), .rxData(rxData), .hsStart(hsStart), .shortDone(shortDone),
		.longDone(longDone), .hsBusy(hsBusy), .transferDirection(transferDirection),
		.byteMatchIrq(byteMatchIrq));
	ppd_host_model u_host (.clk(clk), .rxValid(rxValid), .rxData(rxData));

	task automatic chk(input bit ok, input string m);
		n_compared++;
		if (!ok)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one apb transfer; the answer is awaited, never assumed
	task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			chk(0, "apb hang");
			print_verdict();
		end
		else
		begin
			rdv = prdata;
			erv = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic t_reset();
		acc(0, {3'b000, OFS_MIN_DELAY}, 0);
		chk(rdv === 32'h428, "delay reset");
		for (int i = 0; i < 3; i++)
		begin
			acc(0, {3'b000, mo[i]}, 0);
			chk(rdv === 32'h0, "match reset");
		end
		chk(transferDirection === 1'b0 && byteMatchIrq === 1'b0, "out reset");
	endtask

	task automatic t_map();
		acc(0, 32'h1d0000b0, 0);
		chk(erv === 1'b1 && rdv === 32'h0, "unmapped");
		acc(1, {3'b101, OFS_MATCH_A}, 32'h5a);
		acc(0, {3'b000, OFS_MATCH_A}, 0);
		chk(erv === 1'b0 && rdv === 32'h5a, "alias");
	endtask

	task automatic t_match();
		logic [31:0] bit_i;
		for (int i = 0; i < 3; i++)
			acc(1, {3'b000, mo[i]}, {24'h0, mv[i]});
		for (int i = 0; i < 3; i++)
		begin
			bit_i = 32'h1 << (14 + i);
			u_host.send(mv[i]);
			acc(0, {3'b000, OFS_IRQ_STATUS}, 0);
			chk(rdv === bit_i && byteMatchIrq === 1'b0, "masked match");
			acc(1, {3'b000, OFS_IRQ_ENABLE}, bit_i);
			repeat (2) @(posedge clk);
			chk(byteMatchIrq === 1'b1, "irq on");
			acc(1, {3'b000, OFS_IRQ_CLEAR}, bit_i);
			repeat (2) @(posedge clk);
			chk(byteMatchIrq === 1'b0, "irq off");
			acc(1, {3'b000, OFS_IRQ_ENABLE}, 0);
		end
	endtask

	task automatic t_dir();
		acc(1, {3'b000, OFS_PORT_MODE}, 32'h8);
		// the direction flop updates at the commit edge, so look one edge later
		@(posedge clk);
		chk(transferDirection === 1'b1, "dir read");
		u_host.send(8'h5a);
		acc(0, {3'b000, OFS_IRQ_STATUS}, 0);
		chk(rdv === 32'h0, "reverse byte");
		acc(1, {3'b000, OFS_PORT_MODE}, 32'h0);
		@(posedge clk);
		chk(transferDirection === 1'b0, "dir write");
		u_host.send(8'h5a);
		acc(0, {3'b000, OFS_IRQ_STATUS}, 0);
		chk(rdv === 32'h4000, "forward byte");
		acc(1, {3'b000, OFS_IRQ_CLEAR}, 32'h4000);
	endtask

	task automatic hs(input logic [6:0] s, input logic [6:0] l, output int ts, output int tl);
		acc(1, {3'b000, OFS_MIN_DELAY}, {18'h0, l, s});
		ts = -1;
		tl = -1;
		@(posedge clk);
		hsStart <= 1'b1;
		@(posedge clk);
		hsStart <= 1'b0;
		for (int i = 0; i < 400 && tl < 0; i++)
		begin
			@(posedge clk);
			if (shortDone === 1'b1)
				ts = i;
			if (longDone === 1'b1)
				tl = i;
		end
		if (tl < 0)
		begin
			chk(0, "handshake hang");
			print_verdict();
		end
		repeat (3) @(posedge clk);
		chk(hsBusy === 1'b0 && ts >= 0 && ts < tl, "handshake order");
	endtask

	task automatic t_hs();
		int s1, l1, s2, l2;
		hs(7'h02, 7'h03, s1, l1);
		hs(7'h06, 7'h09, s2, l2);
		chk(s2 - s1 == 4, "short count");
		chk((l2 - s2) - (l1 - s1) == 6, "long count");
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_map();
		t_match();
		t_dir();
		t_hs();
		print_verdict();
	end
endmodule

bind ppd_top ppd_top_sva u_sva (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxValid(rxValid), .rxData(rxData), .hsStart(hsStart),
	.shortDone(shortDone), .longDone(longDone), .hsBusy(hsBusy),
	.transferDirection(transferDirection), .byteMatchIrq(byteMatchIrq));
`default_nettype wire
